// ===== hw/pvfb_pkg.sv
// package: register map, field layout and timing constants of the foldback register slice
package pvfb_pkg;
	localparam int unsigned NUM_CHAN = 4;
	localparam logic [7:0] CMD_CHAN_FOUR_VOLT = 8'h3E;
	localparam logic [7:0] CMD_FOLDBACK_SEL = 8'h40;
	localparam logic [7:0] CMD_FIRMWARE_VER = 8'h41;
	localparam logic [15:0] RST_CHAN_FOUR_VOLT = 16'h0000;
	localparam logic [7:0] RST_FOLDBACK_SEL = 8'h00;
	localparam logic [7:0] RST_FIRMWARE_VER = 8'h00;
	localparam int unsigned DFB_POS = 4;
	localparam int unsigned MPOL_POS = 0;
	localparam int unsigned VOLT_CODE_WIDTH = 14;
	localparam real VOLTAGE_LSB_WEIGHT_MV = 3.662;
	localparam real VOLTAGE_FULL_SCALE_V = 60.0;
	localparam logic [2:0] AUTO_DFB_MIN_CLASS = 3'h4;
	localparam int unsigned CLOCK_MHZ = 125;
	localparam int unsigned LIMIT_FAULT_TIME_MS = 60;
	localparam int unsigned LIMIT_FAULT_CYCLES = LIMIT_FAULT_TIME_MS * 1000 * CLOCK_MHZ;
	localparam int unsigned TICK_US = 1;
	localparam int unsigned TICK_CYCLES = TICK_US * CLOCK_MHZ;
	localparam logic [15:0] POLICING_DEFAULT = 16'hFFFF;
	// per-channel events from the power path
	typedef struct packed {
		logic turn_on;
		logic turn_off;
		logic over_limit;
		logic [2:0] assigned_class;
	} pvfb_chan_evt_t;
	// per-channel settings to the power path
	typedef struct packed {
		logic double_foldback_enable;
		logic policing_auto_load;
		logic policing_restore;
		logic fault_timer_run;
		logic fault_expired;
	} pvfb_chan_ctl_t;
endpackage : pvfb_pkg

// ===== hw/pvfb_fault_timer.sv
// one channel's limit fault timer with selectable duration
module pvfb_fault_timer #(
	parameter int unsigned NOMINAL_TICKS = 60000
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic tick,
	input wire logic over_limit,
	input wire logic use_programmed,
	input wire logic [15:0] programmed_ticks,
	output logic running,
	output logic expired
);
	logic [15:0] count_reg;
	logic [15:0] limit;
	// programmable duration only while double foldback is active
	assign limit = use_programmed ? programmed_ticks : 16'(NOMINAL_TICKS);
	// counts while over the current limit, clears when current drops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_reg <= 16'h0000;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (!over_limit) begin
			count_reg <= 16'h0000;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			running <= 1'b1;
			if (tick && count_reg < limit)
				count_reg <= count_reg + 16'h0001;
			expired <= (count_reg >= limit);
		end
	end
endmodule : pvfb_fault_timer

// ===== hw/pvfb_regs.sv
// foldback and policing register slice with channel four voltage telemetry
// Operation
// - channel four voltage at 3Eh, low byte first
// - voltage is unsigned 14-bit code, 3.662 mV steps
// - foldback select at 40h, one byte read/write
// - double foldback raises limit and short thresholds
// - fault timer starts when current exceeds limit
// - inrush profile ignores double foldback bits
// - cleared bit uses nominal 60 ms fault time
// - set bit uses programmed fault time
// - class four or above sets double foldback
// - hold clear lets turn-on adjust from class
// - hold set leaves settings unchanged at turn-on
// - turn-off restores policing and foldback defaults
// - four-pair hold on either channel blocks both
// - turn-off clears the manual policing hold bit
module pvfb_regs #(
	parameter int unsigned NUM_CHAN = pvfb_pkg::NUM_CHAN,
	parameter logic [7:0] FIRMWARE_VERSION = 8'h5A, // arbitrary value
	parameter int unsigned NOMINAL_TICKS = pvfb_pkg::LIMIT_FAULT_CYCLES / pvfb_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] cmd_addr,
	input wire logic rd_strobe,
	input wire logic wr_strobe,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic [13:0] channel_voltage_code,
	input wire logic [15:0] programmed_fault_ticks,
	input wire logic [1:0] four_pair_port,
	input wire pvfb_pkg::pvfb_chan_evt_t [3:0] chan_evt,
	output pvfb_pkg::pvfb_chan_ctl_t [3:0] chan_ctl,
	output logic [3:0] limit_raise
);
	logic [7:0] fb_sel_reg;
	logic [7:0] fb_sel_next;
	logic [7:0] volt_msb_reg; // latched upper byte so both bytes are one sample
	logic rd_second_reg; // next read of 3Eh returns the upper byte
	logic [7:0] rd_data_next;
	logic [6:0] tick_div_reg;
	logic tick;
	logic [3:0] dfb;
	logic [3:0] hold;
	logic [3:0] hold_eff;
	logic [3:0] run_w;
	logic [3:0] exp_w;
	logic [3:0] dfb_next;
	logic [3:0] hold_next;
	logic [15:0] volt_word;
	logic sel_volt;
	logic sel_fb;
	logic sel_fw;

	assign dfb = fb_sel_reg[pvfb_pkg::DFB_POS +: 4];
	assign hold = fb_sel_reg[pvfb_pkg::MPOL_POS +: 4];
	// zero-extend the code so the two top bits read as zero
	assign volt_word = {2'b00, channel_voltage_code};
	assign sel_volt = (cmd_addr == pvfb_pkg::CMD_CHAN_FOUR_VOLT);
	assign sel_fb = (cmd_addr == pvfb_pkg::CMD_FOLDBACK_SEL);
	assign sel_fw = (cmd_addr == pvfb_pkg::CMD_FIRMWARE_VER);
	assign tick = (tick_div_reg == 7'(pvfb_pkg::TICK_CYCLES - 1));

	// four-pair pairs share the hold: channels 1-2 and 3-4
	assign hold_eff[0] = hold[0] | (four_pair_port[0] & hold[1]);
	assign hold_eff[1] = hold[1] | (four_pair_port[0] & hold[0]);
	assign hold_eff[2] = hold[2] | (four_pair_port[1] & hold[3]);
	assign hold_eff[3] = hold[3] | (four_pair_port[1] & hold[2]);

	// per-channel next values: host write, then turn-on, turn-off wins last
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			logic wr_dfb;
			logic wr_hold;
			logic auto_on;
			assign wr_dfb = (wr_strobe && sel_fb) ? wr_data[pvfb_pkg::DFB_POS + gi] : dfb[gi];
			assign wr_hold = (wr_strobe && sel_fb) ? wr_data[pvfb_pkg::MPOL_POS + gi] : hold[gi];
			assign auto_on = chan_evt[gi].turn_on && !hold_eff[gi];
			// restore default on turn-off regardless of hold
			assign dfb_next[gi] = chan_evt[gi].turn_off ? 1'b0 :
				auto_on ? (chan_evt[gi].assigned_class >= pvfb_pkg::AUTO_DFB_MIN_CLASS) :
				wr_dfb;
			assign hold_next[gi] = chan_evt[gi].turn_off ? 1'b0 : wr_hold;
			pvfb_fault_timer #(
				.NOMINAL_TICKS(NOMINAL_TICKS)
			) u_timer (
				.clock(clock),
				.rst(rst),
				.tick(tick),
				.over_limit(chan_evt[gi].over_limit),
				.use_programmed(dfb[gi]),
				.programmed_ticks(programmed_fault_ticks),
				.running(run_w[gi]),
				.expired(exp_w[gi])
			);
		end
	endgenerate

	always_comb begin
		fb_sel_next = fb_sel_reg;
		fb_sel_next[pvfb_pkg::DFB_POS +: 4] = dfb_next;
		fb_sel_next[pvfb_pkg::MPOL_POS +: 4] = hold_next;
	end

	// read mux; unmapped commands return zero, writes to 3Eh/41h fall through
	always_comb begin
		rd_data_next = 8'h00;
		if (sel_volt)
			rd_data_next = rd_second_reg ? volt_msb_reg : volt_word[7:0];
		else if (sel_fb)
			rd_data_next = fb_sel_reg;
		else if (sel_fw)
			rd_data_next = FIRMWARE_VERSION;
	end

	// microsecond tick divider for the fault timers
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			tick_div_reg <= 7'h00;
		else if (tick)
			tick_div_reg <= 7'h00;
		else
			tick_div_reg <= tick_div_reg + 7'h01;
	end

	// register storage
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			fb_sel_reg <= pvfb_pkg::RST_FOLDBACK_SEL;
		else
			fb_sel_reg <= fb_sel_next;
	end

	// two-byte voltage read: low byte first latches the upper byte
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_second_reg <= 1'b0;
			volt_msb_reg <= 8'h00;
		end else if (rd_strobe && sel_volt) begin
			rd_second_reg <= !rd_second_reg;
			if (!rd_second_reg)
				volt_msb_reg <= volt_word[15:8];
		end else if (rd_strobe) begin
			rd_second_reg <= 1'b0;
		end
	end

	// read answer registered, one cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_strobe;
			if (rd_strobe)
				rd_data <= rd_data_next;
		end
	end

	// outputs to the power path; inrush logic never sees dfb
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			chan_ctl <= '0;
			limit_raise <= 4'h0;
		end else begin
			limit_raise <= dfb;
			for (int i = 0; i < 4; i++) begin
				chan_ctl[i].double_foldback_enable <= dfb[i];
				chan_ctl[i].policing_auto_load <= chan_evt[i].turn_on && !hold_eff[i];
				chan_ctl[i].policing_restore <= chan_evt[i].turn_off;
				chan_ctl[i].fault_timer_run <= run_w[i];
				chan_ctl[i].fault_expired <= exp_w[i];
			end
		end
	end
endmodule : pvfb_regs

// ===== bench/pvfb_regs_checker.sv
// checker: port timing of the foldback register slice
module pvfb_regs_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] cmd_addr,
	input wire logic rd_strobe,
	input wire logic wr_strobe,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire pvfb_pkg::pvfb_chan_evt_t [3:0] chan_evt,
	input wire pvfb_pkg::pvfb_chan_ctl_t [3:0] chan_ctl,
	input wire logic [3:0] limit_raise
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic q; // no turn event anywhere, so a host write cannot be overridden
	always_comb begin
		q = 1'b1;
		for (int i = 0; i < 4; i++) if (chan_evt[i].turn_on | chan_evt[i].turn_off) q = 1'b0;
	end
	a_read_answer: assert property (rd_strobe |=> rd_valid)
		else $error("read not answered");
	a_valid_single: assert property (!rd_strobe |=> !rd_valid)
		else $error("spurious read valid");
	a_data_holds: assert property (!rd_strobe |=> $stable(rd_data))
		else $error("read data moved without a read");
	a_fb_write: assert property (wr_strobe && cmd_addr == 8'h40 && q ##1 (q && !wr_strobe)
		|=> limit_raise == 4'($past(wr_data, 2) >> 4)) else $error("foldback write lost");
	a_off_clears: assert property (chan_evt[0].turn_off ##1 (q && !wr_strobe)
		|=> !limit_raise[0]) else $error("turn-off left foldback set");
	a_restore_pulse: assert property (chan_evt[0].turn_off
		|-> ##[1:2] chan_ctl[0].policing_restore) else $error("no policing restore");
	a_timer_start: assert property ($rose(chan_evt[0].over_limit)
		|-> ##[1:2] chan_ctl[0].fault_timer_run) else $error("fault timer not started");
	a_timer_idle: assert property (!chan_evt[0].over_limit [*3]
		|-> !chan_ctl[0].fault_timer_run) else $error("fault timer runs below limit");
endmodule : pvfb_regs_checker
bind pvfb_regs pvfb_regs_checker pvfb_regs_checker_inst (.clock(clock), .rst(rst),
	.cmd_addr(cmd_addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data),
	.rd_data(rd_data), .rd_valid(rd_valid), .chan_evt(chan_evt), .chan_ctl(chan_ctl),
	.limit_raise(limit_raise));

// ===== bench/pvfb_host.sv
// host model: one-byte command reads and writes
module pvfb_host (
	input wire logic clock,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic [7:0] cmd_addr,
	output logic rd_strobe,
	output logic wr_strobe,
	output logic [7:0] wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {cmd_addr, rd_strobe, wr_strobe, wr_data} = '0;
	// released lines show the inverse so stale values never pass
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock) {cmd_addr, wr_data, wr_strobe} = {a, d, 1'b1};
		@(negedge clock) {cmd_addr, wr_data, wr_strobe} = {~a, ~d, 1'b0};
	endtask : wr
	// answer is a one-cycle pulse, so it is taken in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [8:0] v);
		@(negedge clock) {cmd_addr, rd_strobe} = {a, 1'b1};
		@(negedge clock) {cmd_addr, rd_strobe} = {~a, 1'b0};
		v = {rd_valid, rd_data};
	endtask : rd
endmodule : pvfb_host

// ===== bench/pvfb_regs_tb.sv
// testbench: register access, turn-on policy and fault timing
module pvfb_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] FW = 8'hC3; // arbitrary revision value
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] cmd_addr, wr_data, rd_data;
	logic rd_strobe, wr_strobe, rd_valid;
	logic [1:0] pair = 2'h0;
	pvfb_pkg::pvfb_chan_evt_t [3:0] evt = '0;
	pvfb_pkg::pvfb_chan_ctl_t [3:0] ctl;
	logic [3:0] raise;
	logic [8:0] v;
	int err_total = 0;
	int tests_run = 0;
	always #4 clock = ~clock;
	pvfb_host pvfb_host_inst (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
		.cmd_addr(cmd_addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data));
	// short nominal time keeps the run small
	pvfb_regs #(.FIRMWARE_VERSION(FW), .NOMINAL_TICKS(20)) pvfb_regs_inst (.clock(clock),
		.rst(rst), .cmd_addr(cmd_addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
		.wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
		.channel_voltage_code(14'h3ABC), .programmed_fault_ticks(16'h0003),
		.four_pair_port(pair), .chan_evt(evt), .chan_ctl(ctl), .limit_raise(raise));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task results;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	// read one byte, expecting the valid pulse with it
	task rchk(input logic [7:0] a, input logic [7:0] e);
		pvfb_host_inst.rd(a, v);
		check({7'h0, v}, {8'h01, e});
	endtask : rchk
	// one turn-on or turn-off pulse, then settle
	task ev(input int c, input logic on, input logic [2:0] cls);
		@(negedge clock) {evt[c].turn_on, evt[c].turn_off, evt[c].assigned_class} = {on, ~on, cls};
		@(negedge clock) {evt[c].turn_on, evt[c].turn_off} = 2'b00;
		repeat (3) @(negedge clock);
	endtask : ev
	// over limit until expiry; exp is the length in 125-cycle ticks
	task tm(input int exp);
		int n;
		n = 0;
		@(negedge clock) evt[0].over_limit = 1'b1;
		// run flag is two flops deep: timer then output register
		repeat (2) @(negedge clock);
		check(ctl[0].fault_timer_run, 1'b1);
		while (ctl[0].fault_expired !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > 4000) begin
				err_total++;
				$display("ERROR %0t fault timer never expired", $time);
				results();
			end
		end
		check(16'(n > exp * 125 - 130 && n < exp * 125 + 130), 1'b1);
		evt[0].over_limit = 1'b0;
		repeat (3) @(negedge clock);
	endtask : tm
	task t_regs;
		rchk(8'h40, 8'h00);
		rchk(8'h3E, 8'hBC);
		rchk(8'h3E, 8'h3A);
		pvfb_host_inst.wr(8'h3E, 8'hFF);
		rchk(8'h3E, 8'hBC);
		rchk(8'h50, 8'h00);
		pvfb_host_inst.wr(8'h40, 8'hA5);
		rchk(8'h40, 8'hA5);
		check(raise, 4'hA);
		$display("t_regs done");
	endtask : t_regs
	task t_auto;
		pvfb_host_inst.wr(8'h40, 8'h00);
		ev(0, 1'b1, 3'h4);
		check(raise, 4'h1);
		ev(1, 1'b1, 3'h3);
		check(raise, 4'h1);
		ev(0, 1'b0, 3'h4);
		check(raise, 4'h0);
		pvfb_host_inst.wr(8'h40, 8'h22);
		ev(1, 1'b1, 3'h3);
		check(raise, 4'h2);
		ev(1, 1'b0, 3'h3);
		rchk(8'h40, 8'h00);
		pair = 2'h1;
		pvfb_host_inst.wr(8'h40, 8'h01);
		ev(1, 1'b1, 3'h4);
		check(raise, 4'h0);
		$display("t_auto done");
	endtask : t_auto
	initial begin
		repeat (20) @(negedge clock);
		rst = 1'b0;
		t_regs();
		t_auto();
		pvfb_host_inst.wr(8'h40, 8'h10);
		tm(3);
		pvfb_host_inst.wr(8'h40, 8'h00);
		tm(20);
		$display("t_timer done");
		results();
	end
endmodule : pvfb_regs_tb
